// ===== hw/cra_pkg.sv
package cra_pkg;

  // ----------------------------------------------------------------
  // Bit attributes
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    CRA_RW    = 4'h0,
    CRA_RC    = 4'h1,
    CRA_RC_WR = 4'h2,
    CRA_W1C   = 4'h3,
    CRA_W0C   = 4'h4,
    CRA_W1S   = 4'h5,
    CRA_W0S   = 4'h6,
    CRA_LOCK  = 4'h7,
    CRA_ONCE  = 4'h8
  } cra_attr_t;

  // ----------------------------------------------------------------
  // Address map
  // ----------------------------------------------------------------
  localparam logic [3:0]  REGION_ECAM = 4'h0;
  localparam logic [3:0]  REGION_LEG  = 4'h1;
  localparam logic [11:0] LEG_ADDR    = 12'hcf8;
  localparam logic [11:0] LEG_DATA    = 12'hcfc;
  localparam logic [11:0] OFF_ID      = 12'h000;
  localparam logic [11:0] OFF_CTRL    = 12'h040;
  localparam logic [11:0] OFF_STAT    = 12'h044;
  localparam logic [11:0] OFF_CMD     = 12'h048;
  localparam logic [11:0] OFF_ONCE    = 12'h04c;
  localparam logic [11:0] OFF_STICKY  = 12'h050;
  localparam logic [11:0] OFF_STRAP   = 12'h054;

  localparam logic [1:0]  HIT_NONE    = 2'h0;
  localparam logic [1:0]  HIT_REG     = 2'h1;
  localparam logic [1:0]  HIT_LEGADDR = 2'h2;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int          CTRL_LOCK_BIT = 16;
  localparam int          CMD_KICK_BIT  = 16;
  localparam int          LEG_EN_BIT    = 31;
  localparam logic [7:0]  CTRL_LO_RST   = 8'h00;
  localparam logic [7:0]  CTRL_HI_RST   = 8'h00;
  localparam logic [15:0] ONCE_RST      = 16'h0000;
  localparam logic [3:0]  MODE_RST      = 4'h0;
  localparam logic [31:0] LEG_ADDR_RST  = 32'h0000_0000;
  localparam logic [7:0]  MAX_BUS_TOP   = 8'hff;
  localparam logic [1:0]  AXI_OKAY      = 2'h0;

endpackage : cra_pkg

// ===== hw/cra_attr_bits.sv
`timescale 1ns/10ps
`default_nettype none
module cra_attr_bits #(
  parameter int                 W       = 8,
  parameter cra_pkg::cra_attr_t ATTR    = cra_pkg::CRA_RW,
  parameter logic [W-1:0]       RST_VAL = '0
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         wr_en,
  input  wire logic [W-1:0] wr_data,
  input  wire logic [W-1:0] wr_mask,
  input  wire logic         rd_clr,
  input  wire logic         lock,
  input  wire logic [W-1:0] hw_set,
  input  wire logic [W-1:0] hw_clr,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  output logic      [W-1:0] value_q
);

  logic [W-1:0] value_d;
  logic [W-1:0] once_q;
  logic [W-1:0] once_d;
  logic [W-1:0] wm;

  // ----------------------------------------------------------------
  // Next value
  // ----------------------------------------------------------------
  always_comb begin
    wm      = wr_en ? wr_mask : '0;
    once_d  = once_q;
    value_d = value_q;
    // Clear before the write so a same-cycle write still lands
    if ((ATTR == cra_pkg::CRA_RC || ATTR == cra_pkg::CRA_RC_WR) && rd_clr) begin
      value_d = '0;
    end
    value_d = value_d & ~hw_clr;
    case (ATTR)
      cra_pkg::CRA_RW: value_d = (value_d & ~wm) | (wr_data & wm);
      cra_pkg::CRA_RC_WR: value_d = (value_d & ~wm) | (wr_data & wm);
      cra_pkg::CRA_W1C: value_d = value_d & ~(wm & wr_data);
      cra_pkg::CRA_W0C: value_d = value_d & ~(wm & ~wr_data);
      cra_pkg::CRA_W1S: value_d = value_d | (wm & wr_data);
      cra_pkg::CRA_W0S: value_d = value_d | (wm & ~wr_data);
      cra_pkg::CRA_LOCK: begin
        if (!lock) begin
          value_d = (value_d & ~wm) | (wr_data & wm);
        end
      end
      cra_pkg::CRA_ONCE: begin
        wm      = wm & ~once_q;
        value_d = (value_d & ~wm) | (wr_data & wm);
        once_d  = once_q | wm;
      end
      default: ;
    endcase
    value_d = value_d | hw_set;
    if (load) begin
      value_d = load_val;
    end
  end

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      value_q <= RST_VAL;
    end else begin
      value_q <= value_d;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      once_q <= '0;
    end else begin
      once_q <= once_d;
    end
  end

endmodule : cra_attr_bits
`default_nettype wire

// ===== hw/cra_config_regs.sv
`timescale 1ns/10ps
`default_nettype none
module cra_config_regs #(
  parameter logic [31:0] ID_VALUE = 32'h5a5a_0001 // Arbitrary identity value
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        power_good_resetn,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [2:0]  socket_id,
  input  wire logic [7:0]  strap_value,
  input  wire logic [1:0]  strap_bus_range,
  input  wire logic        hw_lock,
  input  wire logic [7:0]  hw_status,
  input  wire logic [7:0]  hw_status_zc,
  input  wire logic [7:0]  hw_status_rc,
  input  wire logic [7:0]  hw_status_rc_wr,
  input  wire logic [7:0]  hw_sticky,
  input  wire logic [7:0]  cmd_done,
  input  wire logic [7:0]  cmd_zs_done,
  output logic [15:0]      ctrl_out,
  output logic             lock_out,
  output logic [7:0]       cmd_out,
  output logic [7:0]       cmd_zs_out,
  output logic [15:0]      once_out,
  output logic [3:0]       mode_out,
  output logic [7:0]       strap_reg_out,
  output logic             kick_pulse,
  output logic [7:0]       claimed_bus
);

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  // Expands byte strobes into a bit mask; byte 0 is the low lane
  function automatic logic [31:0] cra_bytemask(input logic [3:0] strb);
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{strb[i]}};
    end
    return m;
  endfunction : cra_bytemask

  // Returns {hit kind, local byte offset}
  function automatic logic [13:0] cra_decode(input logic [31:0] addr,
                                             input logic [31:0] leg,
                                             input logic [7:0]  bus);
    logic [1:0]  hit;
    logic [11:0] off;
    hit = cra_pkg::HIT_NONE;
    off = {addr[11:2], 2'b00};
    if (addr[31:28] == cra_pkg::REGION_ECAM) begin
      if (addr[27:20] == bus && addr[19:12] == 8'h00) begin
        hit = cra_pkg::HIT_REG;
      end
    end else if (addr[31:28] == cra_pkg::REGION_LEG) begin
      if (off == cra_pkg::LEG_ADDR) begin
        hit = cra_pkg::HIT_LEGADDR;
      end else if (off == cra_pkg::LEG_DATA && leg[cra_pkg::LEG_EN_BIT] &&
                   leg[23:16] == bus && leg[15:8] == 8'h00) begin
        hit = cra_pkg::HIT_REG;
        off = {4'h0, leg[7:2], 2'b00};
      end
    end
    return {hit, off};
  endfunction : cra_decode

  // Supported encodings of the restricted mode field
  function automatic logic cra_mode_ok(input logic [3:0] m);
    return m == 4'h0 || m == 4'h1 || m == 4'h2 || m == 4'h4;
  endfunction : cra_mode_ok

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        aw_got_q;
  logic [31:0] aw_addr_q;
  logic        w_got_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        wr_go;
  logic        rd_go_q;
  logic [31:0] ar_addr_q;
  logic [31:0] leg_addr_q;
  logic        strap_done_q;
  logic [2:0]  socket_q;
  logic [13:0] wdec;
  logic [13:0] rdec;
  logic [31:0] wmask;
  logic        wr_reg;
  logic        rd_reg;
  logic        wr_ctrl;
  logic        wr_stat;
  logic        wr_cmd;
  logic        wr_once;
  logic        wr_sticky;
  logic        wr_strap;
  logic        rd_stat;
  logic        strap_load;
  logic [7:0]  stat_oc;
  logic [7:0]  stat_zc;
  logic [7:0]  stat_rc;
  logic [7:0]  stat_rc_wr;
  logic [7:0]  sticky;
  logic [1:0]  range_q;
  logic [31:0] rd_val;

  // ----------------------------------------------------------------
  // Write channel
  // ----------------------------------------------------------------
  assign s_axi_awready = !aw_got_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_got_q && !s_axi_bvalid;
  assign s_axi_bresp   = cra_pkg::AXI_OKAY;
  assign wr_go         = aw_got_q && w_got_q && !s_axi_bvalid;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      aw_got_q  <= 1'b0;
      aw_addr_q <= 32'h0000_0000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_got_q  <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
    end else if (wr_go) begin
      aw_got_q  <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      w_got_q  <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_got_q  <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end else if (wr_go) begin
      w_got_q  <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_bvalid <= 1'b0;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  assign wdec      = cra_decode(aw_addr_q, leg_addr_q, claimed_bus);
  assign wmask     = cra_bytemask(w_strb_q);
  assign wr_reg    = wr_go && wdec[13:12] == cra_pkg::HIT_REG;
  assign wr_ctrl   = wr_reg && wdec[11:0] == cra_pkg::OFF_CTRL;
  assign wr_stat   = wr_reg && wdec[11:0] == cra_pkg::OFF_STAT;
  assign wr_cmd    = wr_reg && wdec[11:0] == cra_pkg::OFF_CMD;
  assign wr_once   = wr_reg && wdec[11:0] == cra_pkg::OFF_ONCE;
  assign wr_sticky = wr_reg && wdec[11:0] == cra_pkg::OFF_STICKY;
  assign wr_strap  = wr_reg && wdec[11:0] == cra_pkg::OFF_STRAP;

  // The address register merges the write under the byte strobes
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      leg_addr_q <= cra_pkg::LEG_ADDR_RST;
    end else if (wr_go && wdec[13:12] == cra_pkg::HIT_LEGADDR) begin
      leg_addr_q <= (leg_addr_q & ~wmask) | (w_data_q & wmask);
    end
  end

  // Event bit has no storage behind it; only the pulse exists
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      kick_pulse <= 1'b0;
    end else begin
      kick_pulse <= wr_cmd && wmask[cra_pkg::CMD_KICK_BIT] &&
                    w_data_q[cra_pkg::CMD_KICK_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Straps and bus number
  // ----------------------------------------------------------------
  // Straps are caught on the first edge after release, never in reset
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      strap_done_q <= 1'b0;
    end else begin
      strap_done_q <= 1'b1;
    end
  end

  assign strap_load = !strap_done_q;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      socket_q <= 3'h0;
    end else if (strap_load) begin
      socket_q <= socket_id;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      claimed_bus <= cra_pkg::MAX_BUS_TOP;
    end else begin
      claimed_bus <= (cra_pkg::MAX_BUS_TOP >> range_q) - {5'h00, socket_q};
    end
  end

  // ----------------------------------------------------------------
  // Register bits
  // ----------------------------------------------------------------
  cra_attr_bits #(.W(8), .ATTR(cra_pkg::CRA_RW), .RST_VAL(cra_pkg::CTRL_LO_RST)) u_ctrl_lo (
    .clk(clk), .rst_n(resetn), .wr_en(wr_ctrl), .wr_data(w_data_q[7:0]),
    .wr_mask(wmask[7:0]), .rd_clr(1'b0), .lock(1'b0), .hw_set(8'h00), .hw_clr(8'h00),
    .load(1'b0), .load_val(8'h00), .value_q(ctrl_out[7:0]));

  cra_attr_bits #(.W(8), .ATTR(cra_pkg::CRA_LOCK), .RST_VAL(cra_pkg::CTRL_HI_RST)) u_ctrl_hi (
    .clk(clk), .rst_n(resetn), .wr_en(wr_ctrl), .wr_data(w_data_q[15:8]),
    .wr_mask(wmask[15:8]), .rd_clr(1'b0), .lock(lock_out || hw_lock),
    .hw_set(8'h00), .hw_clr(8'h00), .load(1'b0), .load_val(8'h00),
    .value_q(ctrl_out[15:8]));

  // Lock bit locks itself: once set it holds until resetn is asserted
  cra_attr_bits #(.W(1), .ATTR(cra_pkg::CRA_LOCK), .RST_VAL(1'b0)) u_lock (
    .clk(clk), .rst_n(resetn), .wr_en(wr_ctrl),
    .wr_data(w_data_q[cra_pkg::CTRL_LOCK_BIT]), .wr_mask(wmask[cra_pkg::CTRL_LOCK_BIT]),
    .rd_clr(1'b0), .lock(lock_out), .hw_set(1'b0), .hw_clr(1'b0),
    .load(1'b0), .load_val(1'b0), .value_q(lock_out));

  cra_attr_bits #(.W(8), .ATTR(cra_pkg::CRA_W1C), .RST_VAL(8'h00)) u_stat_oc (
    .clk(clk), .rst_n(resetn), .wr_en(wr_stat), .wr_data(w_data_q[7:0]),
    .wr_mask(wmask[7:0]), .rd_clr(1'b0), .lock(1'b0), .hw_set(hw_status),
    .hw_clr(8'h00), .load(1'b0), .load_val(8'h00), .value_q(stat_oc));

  cra_attr_bits #(.W(8), .ATTR(cra_pkg::CRA_W0C), .RST_VAL(8'h00)) u_stat_zc (
    .clk(clk), .rst_n(resetn), .wr_en(wr_stat), .wr_data(w_data_q[15:8]),
    .wr_mask(wmask[15:8]), .rd_clr(1'b0), .lock(1'b0), .hw_set(hw_status_zc),
    .hw_clr(8'h00), .load(1'b0), .load_val(8'h00), .value_q(stat_zc));

  cra_attr_bits #(.W(8), .ATTR(cra_pkg::CRA_RC), .RST_VAL(8'h00)) u_stat_rc (
    .clk(clk), .rst_n(resetn), .wr_en(wr_stat), .wr_data(w_data_q[23:16]),
    .wr_mask(wmask[23:16]), .rd_clr(rd_stat), .lock(1'b0), .hw_set(hw_status_rc),
    .hw_clr(8'h00), .load(1'b0), .load_val(8'h00), .value_q(stat_rc));

  cra_attr_bits #(.W(8), .ATTR(cra_pkg::CRA_RC_WR), .RST_VAL(8'h00)) u_stat_rc_wr (
    .clk(clk), .rst_n(resetn), .wr_en(wr_stat), .wr_data(w_data_q[31:24]),
    .wr_mask(wmask[31:24]), .rd_clr(rd_stat), .lock(1'b0), .hw_set(hw_status_rc_wr),
    .hw_clr(8'h00), .load(1'b0), .load_val(8'h00), .value_q(stat_rc_wr));

  cra_attr_bits #(.W(8), .ATTR(cra_pkg::CRA_W1S), .RST_VAL(8'h00)) u_cmd_os (
    .clk(clk), .rst_n(resetn), .wr_en(wr_cmd), .wr_data(w_data_q[7:0]),
    .wr_mask(wmask[7:0]), .rd_clr(1'b0), .lock(1'b0), .hw_set(8'h00),
    .hw_clr(cmd_done), .load(1'b0), .load_val(8'h00), .value_q(cmd_out));

  cra_attr_bits #(.W(8), .ATTR(cra_pkg::CRA_W0S), .RST_VAL(8'h00)) u_cmd_zs (
    .clk(clk), .rst_n(resetn), .wr_en(wr_cmd), .wr_data(w_data_q[15:8]),
    .wr_mask(wmask[15:8]), .rd_clr(1'b0), .lock(1'b0), .hw_set(8'h00),
    .hw_clr(cmd_zs_done), .load(1'b0), .load_val(8'h00), .value_q(cmd_zs_out));

  cra_attr_bits #(.W(16), .ATTR(cra_pkg::CRA_ONCE), .RST_VAL(cra_pkg::ONCE_RST)) u_once (
    .clk(clk), .rst_n(resetn), .wr_en(wr_once), .wr_data(w_data_q[15:0]),
    .wr_mask(wmask[15:0]), .rd_clr(1'b0), .lock(1'b0), .hw_set(16'h0000),
    .hw_clr(16'h0000), .load(1'b0), .load_val(16'h0000), .value_q(once_out));

  cra_attr_bits #(.W(4), .ATTR(cra_pkg::CRA_RW), .RST_VAL(cra_pkg::MODE_RST)) u_mode (
    .clk(clk), .rst_n(resetn),
    .wr_en(wr_once && cra_mode_ok(w_data_q[19:16])),
    .wr_data(w_data_q[19:16]), .wr_mask(wmask[19:16]), .rd_clr(1'b0), .lock(1'b0),
    .hw_set(4'h0), .hw_clr(4'h0), .load(1'b0), .load_val(4'h0), .value_q(mode_out));

  // Only the power-good reset reaches these bits
  cra_attr_bits #(.W(8), .ATTR(cra_pkg::CRA_W1C), .RST_VAL(8'h00)) u_sticky (
    .clk(clk), .rst_n(power_good_resetn),
    .wr_en(wr_sticky), .wr_data(w_data_q[7:0]), .wr_mask(wmask[7:0]), .rd_clr(1'b0),
    .lock(1'b0), .hw_set(hw_sticky), .hw_clr(8'h00), .load(1'b0), .load_val(8'h00),
    .value_q(sticky));

  cra_attr_bits #(.W(8), .ATTR(cra_pkg::CRA_RW), .RST_VAL(8'h00)) u_strap (
    .clk(clk), .rst_n(resetn), .wr_en(wr_strap), .wr_data(w_data_q[7:0]),
    .wr_mask(wmask[7:0]), .rd_clr(1'b0), .lock(1'b0), .hw_set(8'h00), .hw_clr(8'h00),
    .load(strap_load), .load_val(strap_value), .value_q(strap_reg_out));

  cra_attr_bits #(.W(2), .ATTR(cra_pkg::CRA_RW), .RST_VAL(2'h0)) u_range (
    .clk(clk), .rst_n(resetn), .wr_en(wr_strap), .wr_data(w_data_q[9:8]),
    .wr_mask(wmask[9:8]), .rd_clr(1'b0), .lock(1'b0), .hw_set(2'h0), .hw_clr(2'h0),
    .load(strap_load), .load_val(strap_bus_range), .value_q(range_q));

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  assign s_axi_arready = !rd_go_q && !s_axi_rvalid;
  assign s_axi_rresp   = cra_pkg::AXI_OKAY;
  assign rdec          = cra_decode(ar_addr_q, leg_addr_q, claimed_bus);
  assign rd_reg        = rd_go_q && rdec[13:12] == cra_pkg::HIT_REG;
  assign rd_stat       = rd_reg && rdec[11:0] == cra_pkg::OFF_STAT;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rd_go_q   <= 1'b0;
      ar_addr_q <= 32'h0000_0000;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rd_go_q   <= 1'b1;
      ar_addr_q <= s_axi_araddr;
    end else begin
      rd_go_q   <= 1'b0;
    end
  end

  // Read-only fields come straight from hardware state
  always_comb begin
    rd_val = 32'h0000_0000;
    if (rdec[13:12] == cra_pkg::HIT_LEGADDR) begin
      rd_val = leg_addr_q;
    end else if (rdec[13:12] == cra_pkg::HIT_REG) begin
      case (rdec[11:0])
        cra_pkg::OFF_ID:     rd_val = ID_VALUE;
        cra_pkg::OFF_CTRL:   rd_val = {15'h0000, lock_out, ctrl_out};
        cra_pkg::OFF_STAT:   rd_val = {stat_rc_wr, stat_rc, stat_zc, stat_oc};
        cra_pkg::OFF_CMD:    rd_val = {16'h0000, cmd_zs_out, cmd_out};
        cra_pkg::OFF_ONCE:   rd_val = {12'h000, mode_out, once_out};
        cra_pkg::OFF_STICKY: rd_val = {24'h00_0000, sticky};
        cra_pkg::OFF_STRAP:  rd_val = {5'h00, socket_q, claimed_bus, 6'h00, range_q,
                                       strap_reg_out};
        default:             rd_val = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
    end else if (rd_go_q) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_val;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule : cra_config_regs
`default_nettype wire

// ===== dv/cra_config_regs_properties.sv
`timescale 1ns/10ps
`default_nettype none
module cra_config_regs_properties (
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic [15:0] ctrl_out,
  input wire logic        lock_out,
  input wire logic [15:0] once_out,
  input wire logic [3:0]  mode_out,
  input wire logic        kick_pulse
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  property p_bresp; s_axi_bvalid |-> s_axi_bresp == 2'h0; endproperty
  a_bresp: assert property (p_bresp) else $error("bresp not okay");
  property p_rresp; s_axi_rvalid |-> s_axi_rresp == 2'h0; endproperty
  a_rresp: assert property (p_rresp) else $error("rresp not okay");
  property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
  a_bhold: assert property (p_bhold) else $error("bvalid dropped");
  property p_kick; kick_pulse |-> $rose(s_axi_bvalid) ##1 !kick_pulse; endproperty
  a_kick: assert property (p_kick) else $error("kick not one write pulse");
  property p_lock; lock_out |=> lock_out; endproperty
  a_lock: assert property (p_lock) else $error("lock cleared");
  property p_ctrl_lock; $past(lock_out) |-> $stable(ctrl_out[15:8]); endproperty
  a_ctrl_lock: assert property (p_ctrl_lock) else $error("locked bits moved");
  property p_once; $changed(once_out) |-> ($past(once_out) & ~once_out) == 16'h0; endproperty
  a_once: assert property (p_once) else $error("write-once bit rewritten");
  property p_mode; mode_out inside {4'h0, 4'h1, 4'h2, 4'h4}; endproperty
  a_mode: assert property (p_mode) else $error("unsupported mode stored");
  c_kick: cover property (kick_pulse);
  c_lock: cover property ($rose(lock_out));
  c_mode: cover property ($changed(mode_out));
endmodule : cra_config_regs_properties
bind cra_config_regs cra_config_regs_properties cra_config_regs_properties_inst (
  .clk, .resetn, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_rresp, .s_axi_rvalid,
  .ctrl_out, .lock_out, .once_out, .mode_out, .kick_pulse
);
`default_nettype wire

// ===== dv/cra_config_regs_test.sv
`timescale 1ns/10ps
`default_nettype none
module cra_config_regs_test;
  localparam logic [31:0] ID_V = 32'h12340abc; // Arbitrary identity value
  localparam logic [31:0] B    = 32'h0fe00000;
  localparam logic [31:0] B2   = 32'h07d00000;
  localparam int          N    = 14;
  // Offset, write data, strobes, value read back afterwards
  localparam logic [75:0] R [N] = '{
    {8'h40, 32'ha55a, 4'hf, 32'ha55a}, {8'h00, 32'hffffffff, 4'hf, ID_V},
    {8'h60, 32'hffffffff, 4'hf, 32'h0}, {8'h4c, 32'hf0, 4'h1, 32'hf0},
    {8'h4c, 32'hff0f, 4'h3, 32'hfff0}, {8'h4c, 32'h40000, 4'h4, 32'h4fff0},
    {8'h4c, 32'h30000, 4'h4, 32'h4fff0}, {8'h48, 32'h1ff05, 4'h7, 32'h5},
    {8'h48, 32'hf000, 4'h2, 32'hf05}, {8'h44, 32'h0, 4'h0, 32'h81818181},
    {8'h44, 32'h5500ff01, 4'hf, 32'h55008180}, {8'h44, 32'h0, 4'h2, 32'h80},
    {8'h40, 32'h1ffff, 4'hf, 32'h1ffff}, {8'h40, 32'h0, 4'hf, 32'h1ff00}
  };
  logic        clk = 1'b0, resetn = 1'b0, power_good_resetn = 1'b0, s_axi_awvalid = 1'b0;
  logic        s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata, a;
  logic [7:0]  strap_value = 8'h3c, hs = '0, claimed_bus;
  logic [3:0]  s_axi_wstrb = '0;
  logic [2:0]  sb = 3'h1;
  logic [1:0]  rg = 2'h0;
  logic        hl = 1'b0, lock_out;
  logic [15:0] ctrl_out, once_out;
  logic [7:0]  cmd_out, cmd_zs_out, strap_reg_out;
  logic [3:0]  mode_out;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  int          n_errors = 0, cmp_count = 0;
  // One driver feeds every hardware set and clear input so one pulse exercises them all
  cra_config_regs #(.ID_VALUE(ID_V)) cra_config_regs_inst (
    .clk, .resetn, .power_good_resetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp(),
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp(), .s_axi_rvalid, .s_axi_rready,
    .socket_id(sb), .strap_value, .strap_bus_range(rg), .hw_lock(hl), .hw_status(hs),
    .hw_status_zc(hs), .hw_status_rc(hs), .hw_status_rc_wr(hs), .hw_sticky(hs),
    .cmd_done(hs), .cmd_zs_done(hs), .ctrl_out, .lock_out, .cmd_out, .cmd_zs_out,
    .once_out, .mode_out, .strap_reg_out, .kick_pulse(), .claimed_bus
  );
  initial forever #2 clk = ~clk;
  // Ready and valid are read before this edge's register updates land
  task automatic xf(input logic [31:0] wa, v, input logic [3:0] s, input logic [31:0] ra, e);
    @(posedge clk);
    s_axi_awaddr <= wa;
    s_axi_wdata <= v;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    s_axi_araddr <= ra;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk($sformatf("rdata %h", ra), e, s_axi_rdata);
  endtask : xf
  task automatic chk(input string nm, input logic [31:0] e, s);
    cmp_count++;
    if (s !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic rst(input logic pg);
    resetn <= 1'b0;
    power_good_resetn <= pg;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    power_good_resetn <= 1'b1;
    repeat (3) @(posedge clk);
  endtask : rst
  task automatic report_and_stop();
    $display("errors %0d comparisons %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (5000) @(posedge clk);
    n_errors++;
    report_and_stop();
  end
  initial begin
    rst(1'b0);
    hs <= 8'h81;
    @(posedge clk);
    hs <= 8'h00;
    for (int i = 0; i < N; i++) begin
      a = {B[31:8], R[i][75:68]};
      xf(a, R[i][67:36], R[i][35:32], a, R[i][31:0]);
    end
    chk("ctrl_out", 32'h1ff00, {15'h0000, lock_out, ctrl_out});
    chk("once_out", 32'h4fff0, {12'h000, mode_out, once_out});
    xf(32'h0fd00040, 32'hffffffff, 4'hf, B + 32'h40, 32'h1ff00);
    xf(32'h10000cf8, 32'h80fe0040, 4'hf, 32'h10000cfc, 32'h1ff00);
    xf(32'h10000cfc, 32'haa, 4'h1, B + 32'h40, 32'h1ffaa);
    hs <= 8'h05;
    @(posedge clk);
    hs <= 8'h00;
    xf(B + 32'h48, 32'h0, 4'h0, B + 32'h48, 32'ha00);
    chk("cmd_out", 32'ha00, {16'h0000, cmd_zs_out, cmd_out});
    strap_value <= 8'hc3;
    sb <= 3'h2;
    rg <= 2'h1;
    rst(1'b1);
    xf(B2 + 32'h40, 32'h0, 4'h0, B2 + 32'h4c, 32'h0);
    hl <= 1'b1;
    xf(B2 + 32'h40, 32'h5a5a, 4'hf, B2 + 32'h40, 32'h5a);
    hl <= 1'b0;
    xf(B2 + 32'h54, 32'h0, 4'h0, B2 + 32'h54, 32'h27d01c3);
    chk("claimed_bus", 32'h7d, {24'h00_0000, claimed_bus});
    // Merge the new strap field into the word read back; a blind write would move the bus
    a = {s_axi_rdata[31:8], 8'h5a};
    xf(B2 + 32'h54, a, 4'hf, B2 + 32'h54, 32'h27d015a);
    chk("strap_field", 32'h5a, s_axi_rdata & 32'h0000_00ff);
    chk("strap_reg_out", 32'h5a, {24'h00_0000, strap_reg_out});
    xf(B2 + 32'h50, 32'h0, 4'h0, B2 + 32'h50, 32'h85);
    power_good_resetn <= 1'b0;
    @(posedge clk);
    power_good_resetn <= 1'b1;
    xf(B2 + 32'h50, 32'h0, 4'h0, B2 + 32'h50, 32'h0);
    report_and_stop();
  end
endmodule : cra_config_regs_test
`default_nettype wire
